//--- verilog/bridge_protection_control.sv
// Protection control of a multi half-bridge gate driver: guarded watchdog
// disable, watchdog timeout, drain-source overvoltage shutdown, overcurrent
// filtering, drain reference and amplifier direction selection.
// Assumes decoded frames arrive on ref_clk from the serial interface logic,
// and comparator outputs and the variant strap arrive asynchronously on pins.
`include "bridge_protection_cfg.svh"
`default_nettype none

// What this block does
// - Guard frame then off frame disables watchdog.
// - Guard frame inverts toggle; toggle resets zero.
// - Intervening frame clears guard; watchdog stays.
// - Switch off MOSFET after persistent overvoltage.
// - Overvoltage filter: 0.5, 1, 2, 3 us.
// - Overcurrent filter selectable 6 to 100 us.
// - Drain reference: 1 shunt input, 0 drain.
// - Four-bridge variant: selection only bridges 1-4.
// - Direction select 0 means unidirectional amplifier.
// - Unserved watchdog: flag, fail-safe, all off.
// - Watchdog enabled after reset; frames switch it.
module bridge_protection_control
   import bridge_protection_pkg::*;
#(
   parameter int OC_CYC_2 = `US_TO_CYC(`OC_FILT_2_US),
   parameter int OC_CYC_3 = `US_TO_CYC(`OC_FILT_3_US),
   parameter int WD_SHORT_CYC = `MS_TO_CYC(`WD_SHORT_MS),
   parameter int WD_LONG_CYC = `MS_TO_CYC(`WD_LONG_MS)
)
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic frame_valid,
   input wire logic frame_write,
   input wire logic [6:0] frame_addr,
   input wire logic [7:0] frame_data,
   input wire logic fault_clear,
   input wire logic four_hb_variant,
   input wire logic [15:0] gate_cmd,
   input wire logic [15:0] vds_over,
   input wire logic [1:0] oc_over,
   output logic [15:0] gate_enable,
   output logic [15:0] vds_fault,
   output logic [1:0] oc_fault,
   output logic [7:0] drain_ref_is_shunt,
   output logic [1:0] amp_unidirectional,
   output logic wd_enabled,
   output logic wd_fail,
   output logic fail_safe,
   output logic guard_armed
);

   localparam filt_cnt_t VDS_CYC_0 = 14'(`NS_TO_CYC(`VDS_FILT_0_NS));
   localparam filt_cnt_t VDS_CYC_1 = 14'(`NS_TO_CYC(`VDS_FILT_1_NS));
   localparam filt_cnt_t VDS_CYC_2 = 14'(`NS_TO_CYC(`VDS_FILT_2_NS));
   localparam filt_cnt_t VDS_CYC_3 = 14'(`NS_TO_CYC(`VDS_FILT_3_NS));
   localparam filt_cnt_t OC_CYC_0 = 14'(`US_TO_CYC(`OC_FILT_0_US));
   localparam filt_cnt_t OC_CYC_1 = 14'(`US_TO_CYC(`OC_FILT_1_US));

   // Tells whether the current frame is a write to the given address.
   function automatic logic write_to(input logic v, input logic w, input logic [6:0] a,
                                     input logic [6:0] target);
      write_to = v && w && (a == target);
   endfunction : write_to

   // Filter limit for a two-bit selection out of four choices.
   function automatic filt_cnt_t pick_limit(input logic [1:0] sel, input filt_cnt_t l0,
                                            input filt_cnt_t l1, input filt_cnt_t l2,
                                            input filt_cnt_t l3);
      unique case (sel)
         2'h0: pick_limit = l0;
         2'h1: pick_limit = l1;
         2'h2: pick_limit = l2;
         2'h3: pick_limit = l3;
      endcase
   endfunction : pick_limit

   logic [1:0] rst_sync_q;
   logic rst_n_int;
   logic [15:0] vds_meta_q;
   logic [15:0] vds_sync_q;
   logic [1:0] oc_meta_q;
   logic [1:0] oc_sync_q;
   logic var_meta_q;
   logic var_sync_q;

   // Reset release through two flip-flops.
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         rst_sync_q <= 2'h0;
      else if (clk_en)
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n_int = rst_sync_q[1];

   // Two-stage synchronisers for comparator pins and the variant strap.
   always_ff @(posedge ref_clk or negedge rst_n_int)
   begin
      if (!rst_n_int)
      begin
         vds_meta_q <= 16'h0000;
         vds_sync_q <= 16'h0000;
         oc_meta_q <= 2'h0;
         oc_sync_q <= 2'h0;
         var_meta_q <= 1'b0;
         var_sync_q <= 1'b0;
      end
      else if (clk_en)
      begin
         vds_meta_q <= vds_over;
         vds_sync_q <= vds_meta_q;
         oc_meta_q <= oc_over;
         oc_sync_q <= oc_meta_q;
         var_meta_q <= four_hb_variant;
         var_sync_q <= var_meta_q;
      end
   end

   // Frame decode.
   wire wr_gc1 = write_to(frame_valid, frame_write, frame_addr, `GC1_ADDR);
   wire wr_gc2 = write_to(frame_valid, frame_write, frame_addr, `GC2_ADDR);
   wire wr_hbd = write_to(frame_valid, frame_write, frame_addr, `HBD_ADDR);

   logic guard_q;
   logic toggle_q;
   logic wd_off_q;
   logic [7:0] gc2_q;
   logic [7:0] hbd_q;
   wd_cnt_t wd_cnt_q;

   // Guard arms only on a general_control_one write with the guard bit set;
   // the very next frame disarms it unless it is another guard write.
   wire guard_d = frame_valid ? (wr_gc1 && frame_data[`GC1_GUARD_BIT]) : guard_q;
   // Watchdog off needs the armed guard; writing zero turns it back on.
   wire off_req = wr_gc2 && frame_data[`GC2_WDOFF_BIT];
   wire wd_off_d = off_req ? (guard_q | wd_off_q) :
                   (wr_gc2 ? 1'b0 : wd_off_q);
   // A changed toggle value serves the watchdog.
   wire serve = wr_gc1 && (frame_data[`GC1_TOGGLE_BIT] != toggle_q);
   wire wd_run = !wd_off_q && !fail_safe;
   wire wd_cnt_t wd_limit = gc2_q[`GC2_WDTO_BIT] ? 25'(WD_LONG_CYC - 1) :
                                                  25'(WD_SHORT_CYC - 1);
   wire wd_expire = wd_run && (wd_cnt_q == wd_limit);
   wire wd_cnt_t wd_cnt_d = (!wd_run || serve) ? '0 : wd_cnt_q + 25'h0000001;

   // Control registers and watchdog state.
   always_ff @(posedge ref_clk or negedge rst_n_int)
   begin
      if (!rst_n_int)
      begin
         guard_q <= 1'b0;
         toggle_q <= `TOGGLE_RST;
         wd_off_q <= 1'b0;
         gc2_q <= `GC2_RST;
         hbd_q <= `HBD_RST;
         wd_cnt_q <= '0;
      end
      else if (clk_en)
      begin
         guard_q <= guard_d;
         toggle_q <= wr_gc1 ? frame_data[`GC1_TOGGLE_BIT] : toggle_q;
         wd_off_q <= wd_off_d;
         gc2_q <= wr_gc2 ? frame_data : gc2_q;
         hbd_q <= wr_hbd ? frame_data : hbd_q;
         wd_cnt_q <= wd_cnt_d;
      end
   end

   // Filter limits chosen from the control fields.
   wire filt_cnt_t vds_limit = pick_limit(gc2_q[`GC2_VDSF_LO +: 2], VDS_CYC_0, VDS_CYC_1,
                                          VDS_CYC_2, VDS_CYC_3);
   wire filt_cnt_t oc_limit = pick_limit(gc2_q[`GC2_OCF_LO +: 2], OC_CYC_0, OC_CYC_1,
                                         14'(OC_CYC_2), 14'(OC_CYC_3));

   logic [17:0] trip;

   // One filter per MOSFET for drain-source voltage, one per shunt channel.
   genvar i;
   generate
      for (i = 0; i < 18; i++)
      begin : g_filt
         wire lvl = (i < 16) ? (gate_enable[i % 16] && vds_sync_q[i % 16]) :
                               oc_sync_q[i % 2];
         glitch_filter u_filt (
            .clk(ref_clk),
            .rst_n(rst_n_int),
            .clk_en(clk_en),
            .level(lvl),
            .limit((i < 16) ? vds_limit : oc_limit),
            .tripped(trip[i])
         );
      end
   endgenerate

   // Output values; a new fault wins over a simultaneous clear.
   wire [15:0] vds_fault_d = trip[15:0] | (fault_clear ? 16'h0000 : vds_fault);
   wire [1:0] oc_fault_d = trip[17:16] | (fault_clear ? 2'h0 : oc_fault);
   wire wd_fail_d = wd_expire | (!fault_clear && wd_fail);
   wire fail_safe_d = wd_expire | (!fault_clear && fail_safe);
   wire [15:0] gate_enable_d = gate_cmd & ~vds_fault_d & {16{!fail_safe_d}};
   wire [7:0] drain_ref_d = var_sync_q ? {4'h0, hbd_q[3:0]} : hbd_q;
   wire [1:0] amp_unidir_d = ~gc2_q[`GC2_CSD_LO +: 2];

   // Output registers.
   always_ff @(posedge ref_clk or negedge rst_n_int)
   begin
      if (!rst_n_int)
      begin
         gate_enable <= 16'h0000;
         vds_fault <= 16'h0000;
         oc_fault <= 2'h0;
         drain_ref_is_shunt <= 8'h00;
         amp_unidirectional <= 2'h3;
         wd_enabled <= 1'b1;
         wd_fail <= 1'b0;
         fail_safe <= 1'b0;
         guard_armed <= 1'b0;
      end
      else if (clk_en)
      begin
         gate_enable <= gate_enable_d;
         vds_fault <= vds_fault_d;
         oc_fault <= oc_fault_d;
         drain_ref_is_shunt <= drain_ref_d;
         amp_unidirectional <= amp_unidir_d;
         wd_enabled <= !wd_off_d;
         wd_fail <= wd_fail_d;
         fail_safe <= fail_safe_d;
         guard_armed <= guard_d;
      end
   end

endmodule : bridge_protection_control

`default_nettype wire

//--- verilog/bridge_protection_cfg.svh
// Constants of the bridge protection control block: frame addresses,
// field positions, reset values and timing figures.
// Assumes a 100 MHz ref_clk; every count is derived from the clock rate.
`ifndef BRIDGE_PROTECTION_CFG_SVH
`define BRIDGE_PROTECTION_CFG_SVH

// Clock rate in MHz.
`define CLK_MHZ 100

// Frame register addresses.
`define GC1_ADDR 7'h01
`define GC2_ADDR 7'h02
`define HBD_ADDR 7'h03

// Field positions in general_control_one.
`define GC1_GUARD_BIT 0
`define GC1_TOGGLE_BIT 1

// Field positions in general_control_two.
`define GC2_WDOFF_BIT 0
`define GC2_WDTO_BIT 1
`define GC2_VDSF_LO 2
`define GC2_OCF_LO 4
`define GC2_CSD_LO 6

// Reset values.
`define TOGGLE_RST 1'b0
`define GC2_RST 8'h00
`define HBD_RST 8'h00

// Drain-source overvoltage filter times in ns.
`define VDS_FILT_0_NS 500
`define VDS_FILT_1_NS 1000
`define VDS_FILT_2_NS 2000
`define VDS_FILT_3_NS 3000

// Overcurrent filter times in us.
`define OC_FILT_0_US 6
`define OC_FILT_1_US 12
`define OC_FILT_2_US 50
`define OC_FILT_3_US 100

// Watchdog timeouts in ms.
`define WD_SHORT_MS 50
`define WD_LONG_MS 200

// Conversions from time to cycles; filter times are least times.
`define NS_TO_CYC(ns) (((ns) * `CLK_MHZ + 999) / 1000)
`define US_TO_CYC(us) ((us) * `CLK_MHZ)
`define MS_TO_CYC(ms) ((ms) * 1000 * `CLK_MHZ)

`endif

//--- verilog/bridge_protection_pkg.sv
// Types shared by the bridge protection control files.
// Assumes the constants header is compiled alongside.
`default_nettype none

package bridge_protection_pkg;
   // Filter counter wide enough for the longest overcurrent filter.
   typedef logic [13:0] filt_cnt_t;
   // Watchdog counter wide enough for the longest timeout.
   typedef logic [24:0] wd_cnt_t;
endpackage : bridge_protection_pkg

`default_nettype wire

//--- verilog/glitch_filter.sv
// Persistence filter: reports an input level only after it has stayed
// high for a programmed number of cycles.
// Assumes the level input is already synchronous to clk.
`default_nettype none

module glitch_filter
   import bridge_protection_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic level,
   input wire filt_cnt_t limit,
   output logic tripped
);

   filt_cnt_t cnt_q;
   filt_cnt_t cnt_d;
   logic tripped_d;

   // Any drop of the level restarts the count; the count saturates at limit.
   assign cnt_d = !level ? '0 : (cnt_q < limit) ? cnt_q + 14'h0001 : cnt_q;
   assign tripped_d = level && (cnt_q >= limit);

   // Counter and output register.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q <= '0;
         tripped <= 1'b0;
      end
      else if (clk_en)
      begin
         cnt_q <= cnt_d;
         tripped <= tripped_d;
      end
   end

endmodule : glitch_filter

`default_nettype wire

//--- verification/bridge_protection_props.sv
// Concurrent checks on the ports of the protection control block.
// Assumes it is bound to the top module and that frames start after reset.
`default_nettype none

module bridge_protection_props (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic frame_valid,
   input wire logic frame_write,
   input wire logic [6:0] frame_addr,
   input wire logic [7:0] frame_data,
   input wire logic fault_clear,
   input wire logic [15:0] vds_over,
   input wire logic [15:0] gate_enable,
   input wire logic [15:0] vds_fault,
   input wire logic [7:0] drain_ref_is_shunt,
   input wire logic [1:0] amp_unidirectional,
   input wire logic wd_enabled,
   input wire logic fail_safe,
   input wire logic guard_armed
);
   timeunit 1ns;
   timeprecision 1ps;
   // Decoded write frames that the rules speak of.
   wire logic wr = clk_en & frame_valid & frame_write;
   wire logic arm = wr & (frame_addr == 7'h01) & frame_data[0];
   wire logic off = wr & (frame_addr == 7'h02) & frame_data[0];
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   a_guard_arms: assert property (arm |=> guard_armed)
      else $error("guard frame did not arm");
   a_pair_disables: assert property (off && guard_armed |=> !wd_enabled)
      else $error("ordered pair left watchdog on");
   a_lone_off_refused: assert property (off && !guard_armed && wd_enabled |=> wd_enabled)
      else $error("unguarded off frame took effect");
   a_other_disarms: assert property (clk_en && frame_valid && !arm |=> !guard_armed)
      else $error("guard survived another frame");
   a_wd_on_reset: assert property ($rose(reset_n) |-> wd_enabled)
      else $error("watchdog off after reset");
   a_vds_gate_off: assert property (vds_fault[0] && !fault_clear |=> !gate_enable[0])
      else $error("faulted MOSFET still on");
   a_vds_needs_level: assert property (!vds_over[0] [*8] |=> !$rose(vds_fault[0]))
      else $error("overvoltage trip without level");
   a_safe_all_off: assert property (fail_safe && !fault_clear |=> gate_enable == 16'h0000)
      else $error("gate on in fail-safe");
   // The selection outputs follow their control register one cycle later.
   a_drain_ref: assert property (wr && frame_addr == 7'h03 |-> ##2
      drain_ref_is_shunt[3:0] == $past(frame_data[3:0], 2))
      else $error("drain reference not taken");
   a_amp_dir: assert property (wr && frame_addr == 7'h02 |-> ##2
      amp_unidirectional == ~$past(frame_data[7:6], 2))
      else $error("amplifier direction wrong");
endmodule : bridge_protection_props

bind bridge_protection_control bridge_protection_props u_props (.ref_clk(ref_clk),
   .reset_n(reset_n), .clk_en(clk_en), .frame_valid(frame_valid), .frame_write(frame_write),
   .frame_addr(frame_addr), .frame_data(frame_data), .fault_clear(fault_clear),
   .vds_over(vds_over), .gate_enable(gate_enable), .vds_fault(vds_fault),
   .drain_ref_is_shunt(drain_ref_is_shunt), .amp_unidirectional(amp_unidirectional),
   .wd_enabled(wd_enabled), .fail_safe(fail_safe), .guard_armed(guard_armed));

`default_nettype wire

//--- verification/host_model.sv
// Host model issuing decoded frames, one per cycle.
// Assumes its tasks are entered at a falling edge of clk.
`default_nettype none

module host_model (
   input wire logic clk,
   output logic valid,
   output logic wr,
   output logic [6:0] addr,
   output logic [7:0] data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic tog = 1'b0;
   initial {valid, wr, addr, data} = '0;
   // A frame stays up for exactly one rising edge; back to back is legal.
   task send(input logic [6:0] a, input logic [7:0] d);
      {valid, wr, addr, data} = {2'b11, a, d};
      @(negedge clk);
   endtask : send
   task idle();
      valid = 1'b0;
      @(negedge clk);
   endtask : idle
   // Guard frame with inverted toggle, then the control frame, right after unless cut puts an 8'hff write to 7'h03 between.
   task guarded(input logic [7:0] d, input bit cut);
      tog = ~tog;
      send(7'h01, {6'h00, tog, 1'b1});
      if (cut)
         send(7'h03, 8'hff);
      send(7'h02, d);
      idle();
   endtask : guarded
endmodule : host_model

`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench of the protection control block.
// Assumes the design header and package are compiled first.
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, reset_n, fault_clear, four_hb_variant, fv, fw, ce;
   logic [15:0] gate_cmd, vds_over, gate_enable, vds_fault;
   logic [1:0] oc_over, oc_fault, amp_unidirectional;
   logic [6:0] fa;
   logic [7:0] fd, drain_ref_is_shunt;
   logic wd_enabled, wd_fail, fail_safe, guard_armed;
   int fail_count = 0;
   int n_tests = 0;
   int vlim[4] = '{50, 100, 200, 300};
   int olim[4] = '{600, 1200, 20, 40};
   bridge_protection_control #(.OC_CYC_2(20), .OC_CYC_3(40), .WD_SHORT_CYC(50),
      .WD_LONG_CYC(200)) u_bridge_protection_control (.ref_clk(ref_clk),
      .reset_n(reset_n), .clk_en(ce), .frame_valid(fv), .frame_write(fw),
      .frame_addr(fa), .frame_data(fd), .fault_clear(fault_clear),
      .four_hb_variant(four_hb_variant), .gate_cmd(gate_cmd), .vds_over(vds_over),
      .oc_over(oc_over), .gate_enable(gate_enable), .vds_fault(vds_fault),
      .oc_fault(oc_fault), .drain_ref_is_shunt(drain_ref_is_shunt),
      .amp_unidirectional(amp_unidirectional), .wd_enabled(wd_enabled), .wd_fail(wd_fail),
      .fail_safe(fail_safe), .guard_armed(guard_armed));
   host_model u_host_model (.clk(ref_clk), .valid(fv), .wr(fw), .addr(fa), .data(fd));
   // Free-running 100 MHz clock.
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task results();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : results
   task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // Counts cycles until a flag rises; the bound ends the run on a hang.
   task wait_hit(input int k, input int lo, input int hi);
      int n;
      logic f;
      n = 0;
      f = 1'b0;
      while (f !== 1'b1 && n <= hi)
      begin
         @(negedge ref_clk);
         n++;
         f = (k == 0) ? vds_fault[0] : (k == 1) ? oc_fault[0] : wd_fail;
      end
      check("trip delay in window", 16'(n >= lo && n <= hi), 16'h0001);
      if (n > hi)
         results();
   endtask : wait_hit
   task clear();
      vds_over = 16'h0000;
      oc_over = 2'b00;
      // Let the synchronisers and filters drain so that no trip outlives the clear.
      repeat (4) @(negedge ref_clk);
      fault_clear = 1'b1;
      @(negedge ref_clk);
      fault_clear = 1'b0;
      @(negedge ref_clk);
      check("vds_fault cleared", vds_fault, 16'h0000);
      check("oc_fault cleared", oc_fault, 2'b00);
   endtask : clear
   // Main sequence: reset, watchdog, frames, both filters, then clock enable and the long watchdog.
   initial
   begin
      {reset_n, fault_clear, four_hb_variant, vds_over, oc_over} = '0;
      ce = 1'b1;
      gate_cmd = 16'hffff;
      repeat (16) @(negedge ref_clk);
      reset_n = 1'b1;
      @(negedge ref_clk);
      check("wd_enabled", wd_enabled, 1);
      check("amp_unidirectional", amp_unidirectional, 2'b11);
      wait_hit(2, 49, 58);
      check("fail_safe", fail_safe, 1);
      check("gate_enable safe", gate_enable, 16'h0000);
      u_host_model.guarded(8'h01, 0);
      clear();
      check("wd_enabled off", wd_enabled, 0);
      check("gate_enable", gate_enable, 16'hffff);
      u_host_model.guarded(8'h00, 0);
      u_host_model.guarded(8'h01, 1);
      check("wd_enabled cut", wd_enabled, 1);
      check("guard_armed cut", guard_armed, 0);
      check("drain_ref", drain_ref_is_shunt, 8'hff);
      u_host_model.guarded(8'h41, 0);
      check("amp_unidirectional", amp_unidirectional, 2'b10);
      four_hb_variant = 1'b1;
      repeat (4) @(negedge ref_clk);
      check("drain_ref four", drain_ref_is_shunt, 8'h0f);
      for (int s = 0; s < 4; s++)
      begin
         u_host_model.guarded({4'h4, 2'(s), 2'b01}, 0);
         vds_over[0] = 1'b1;
         repeat (vlim[s] - 10) @(negedge ref_clk);
         vds_over[0] = 1'b0;
         repeat (3) @(negedge ref_clk);
         vds_over[0] = 1'b1;
         check("vds_fault glitch", vds_fault, 16'h0000);
         wait_hit(0, vlim[s], vlim[s] + 8);
         @(negedge ref_clk);
         check("gate_enable vds", gate_enable, 16'hfffe);
         clear();
         u_host_model.guarded({2'b01, 2'(s), 4'h1}, 0);
         oc_over[0] = 1'b1;
         wait_hit(1, olim[s], olim[s] + 8);
         clear();
      end
      // A frame given while the clock enable is low must be ignored.
      ce = 1'b0;
      u_host_model.send(7'h02, 8'hc1);
      u_host_model.idle();
      ce = 1'b1;
      @(negedge ref_clk);
      check("amp_unidirectional frozen", amp_unidirectional, 2'b10);
      u_host_model.send(7'h01, {6'h00, u_host_model.tog, 1'b1});
      check("guard_armed", guard_armed, 1);
      // Re-enable the watchdog with the long timeout and let it starve.
      u_host_model.guarded(8'h02, 0);
      check("guard_armed used", guard_armed, 0);
      check("wd_enabled on", wd_enabled, 1);
      wait_hit(2, 195, 208);
      check("gate_enable long", gate_enable, 16'h0000);
      clear();
      check("fail_safe cleared", {fail_safe, wd_fail}, 2'b00);
      results();
   end
endmodule : testbench

`default_nettype wire
